/* File: logic/cbs_smbus_top.sv */
// management bus target and register file of the four-pair clock buffer
`timescale 1ns/1ns

module cbs_smbus_top #(
  // arbitrary neutral identity value
  parameter logic [7:0] MAKER_ID = 8'h5a
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // management bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // control pins
  input cbs_pkg::cbs_pins_t pins,
  // output stage control
  output cbs_pkg::cbs_pair_ctrl_t pair_ctrl,
  output logic normal_freq,
  output logic pll_mode,
  output logic bw_low
);

  // ************************************************************
  // declarations
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK
  } cbs_state_t;

  cbs_state_t state_q;
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic read_q;
  logic [1:0] byte_no_q;
  logic [7:0] index_q;
  logic [7:0] remain_q;
  logic acked_q;
  logic host_ack_q;
  logic sda_oe_n_q;
  logic wr_en;
  logic [7:0] tx_byte;
  logic [7:0] tx_next;
  logic [7:0] mode_q;
  logic [7:0] enable_q;
  logic [7:0] stop_q;
  logic [7:0] spare_q;
  cbs_pkg::cbs_pins_t pins_s;
  cbs_pkg::cbs_cfg_t cfg;

  // register read mux; unmapped indexes read as zero
  function automatic logic [7:0] rd_reg(input logic [7:0] idx);
    case (idx)
      cbs_pkg::IDX_MODE: rd_reg = mode_q;
      cbs_pkg::IDX_ENABLE: rd_reg = enable_q;
      cbs_pkg::IDX_STOP: rd_reg = stop_q;
      cbs_pkg::IDX_SPARE: rd_reg = spare_q;
      cbs_pkg::IDX_MAKER: rd_reg = MAKER_ID;
      default: rd_reg = 8'h00;
    endcase
  endfunction

  // ************************************************************
  // input synchronisers
  // ************************************************************
  // bus lines idle high, so they reset high to avoid a false start
  cbs_sync #(
    .W(2),
    .RST_VAL(2'h3)
  ) u_bus_sync (
    .clk(clk),
    .reset(reset),
    .din({scl, sda_in}),
    .dout({scl_s, sda_s})
  );

  cbs_sync #(
    .W($bits(cbs_pkg::cbs_pins_t)),
    .RST_VAL('0)
  ) u_pin_sync (
    .clk(clk),
    .reset(reset),
    .din(pins),
    .dout(pins_s)
  );

  // ************************************************************
  // bus event detection
  // ************************************************************
  // previous samples of the synchronised lines
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // start and stop are data edges while the clock line is high
  always_comb
  begin
    scl_rise = scl_s & ~scl_p_q;
    scl_fall = ~scl_s & scl_p_q;
    start_seen = scl_s & scl_p_q & sda_p_q & ~sda_s;
    stop_seen = scl_s & scl_p_q & ~sda_p_q & sda_s;
    byte_done = scl_fall & (bit_cnt_q == cbs_pkg::BITS_PER_BYTE);
    // data bytes past the announced count are refused
    wr_en = (state_q == ST_RX) && byte_done && (byte_no_q == 2'h2)
      && (remain_q != 8'h00);
    tx_byte = (byte_no_q == 2'h0) ? cbs_pkg::READ_BYTE_COUNT : rd_reg(index_q);
    // byte after an acknowledge; only a data byte moves the index on
    tx_next = rd_reg(index_q + {7'h00, byte_no_q == 2'h3});
  end

  // ************************************************************
  // protocol engine
  // ************************************************************
  // the engine only ever pulls the data line; the clock is an input
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      read_q <= 1'b0;
      byte_no_q <= 2'h0;
      index_q <= 8'h00;
      remain_q <= 8'h00;
      acked_q <= 1'b0;
      host_ack_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end
    else if (start_seen)
    begin
      // a repeated start also lands here and keeps the index
      state_q <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_n_q <= 1'b1;
    end
    else if (stop_seen)
    begin
      state_q <= ST_IDLE;
      sda_oe_n_q <= 1'b1;
    end
    else
    begin
      case (state_q)
        ST_ADDR, ST_RX:
        begin
          if (scl_rise)
          begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (byte_done && state_q == ST_ADDR)
          begin
            if (shift_q[7:1] == cbs_pkg::TARGET_ADDR)
            begin
              state_q <= ST_ADDR_ACK;
              read_q <= shift_q[0];
              byte_no_q <= 2'h0;
              sda_oe_n_q <= 1'b0;
            end
            else
            begin
              state_q <= ST_IDLE;
            end
          end
          else if (byte_done)
          begin
            state_q <= ST_RX_ACK;
            case (byte_no_q)
              2'h0:
              begin
                index_q <= shift_q;
                byte_no_q <= 2'h1;
                acked_q <= 1'b1;
                sda_oe_n_q <= 1'b0;
              end
              2'h1:
              begin
                remain_q <= shift_q;
                byte_no_q <= 2'h2;
                acked_q <= 1'b1;
                sda_oe_n_q <= 1'b0;
              end
              default:
              begin
                acked_q <= wr_en;
                sda_oe_n_q <= ~wr_en;
                if (wr_en)
                begin
                  remain_q <= remain_q - 8'h01;
                  index_q <= index_q + 8'h01;
                end
              end
            endcase
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall && read_q)
          begin
            // first read byte is the count, then registers from the index
            state_q <= ST_TX;
            sda_oe_n_q <= tx_byte[7];
            shift_q <= {tx_byte[6:0], 1'b0};
            bit_cnt_q <= 4'h1;
            byte_no_q <= 2'h2;
          end
          else if (scl_fall)
          begin
            state_q <= ST_RX;
            bit_cnt_q <= 4'h0;
            sda_oe_n_q <= 1'b1;
          end
        end
        ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            // a refused byte ends our part in the transfer
            state_q <= acked_q ? ST_RX : ST_IDLE;
            bit_cnt_q <= 4'h0;
            sda_oe_n_q <= 1'b1;
          end
        end
        ST_TX:
        begin
          if (byte_done)
          begin
            state_q <= ST_TX_ACK;
            sda_oe_n_q <= 1'b1;
          end
          else if (scl_fall)
          begin
            sda_oe_n_q <= shift_q[7];
            shift_q <= {shift_q[6:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            host_ack_q <= ~sda_s;
            if (sda_s)
            begin
              state_q <= ST_IDLE;
            end
          end
          else if (scl_fall && host_ack_q)
          begin
            // the count byte does not advance the index
            if (byte_no_q == 2'h3)
            begin
              index_q <= index_q + 8'h01;
            end
            state_q <= ST_TX;
            sda_oe_n_q <= tx_next[7];
            shift_q <= {tx_next[6:0], 1'b0};
            bit_cnt_q <= 4'h1;
            byte_no_q <= 2'h3;
            host_ack_q <= 1'b0;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
          sda_oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  // reserved bits never store, so they read back zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      mode_q <= cbs_pkg::MODE_RST;
      enable_q <= cbs_pkg::ENABLE_RST;
      stop_q <= cbs_pkg::STOP_RST;
      spare_q <= cbs_pkg::SPARE_RST;
    end
    else if (wr_en)
    begin
      case (index_q)
        cbs_pkg::IDX_MODE: mode_q <= shift_q & cbs_pkg::MODE_MASK;
        cbs_pkg::IDX_ENABLE: enable_q <= shift_q & cbs_pkg::PAIR_MASK;
        cbs_pkg::IDX_STOP: stop_q <= shift_q & cbs_pkg::PAIR_MASK;
        cbs_pkg::IDX_SPARE: spare_q <= shift_q & cbs_pkg::SPARE_MASK;
        default: spare_q <= spare_q;
      endcase
    end
  end

  // ************************************************************
  // output control
  // ************************************************************
  always_comb
  begin
    cfg.mode = mode_q;
    cfg.enable = enable_q;
    cfg.stop = stop_q;
  end

  cbs_out_ctrl u_out (
    .clk(clk),
    .reset(reset),
    .cfg(cfg),
    .pins(pins_s),
    .pair_q(pair_ctrl),
    .normal_freq_q(normal_freq),
    .pll_mode_q(pll_mode),
    .bw_low_q(bw_low)
  );

  // open-drain data line: only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe_n = sda_oe_n_q;

endmodule

/* File: logic/cbs_pkg.sv */
// shared constants, field layouts and carrier types for the clock buffer control block
package cbs_pkg;

  // ************************************************************
  // management bus target
  // ************************************************************
  localparam logic [6:0] TARGET_ADDR = 7'h6e;
  localparam logic [7:0] READ_BYTE_COUNT = 8'h05;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ************************************************************
  // register indexes
  // ************************************************************
  localparam logic [7:0] IDX_MODE = 8'h00;
  localparam logic [7:0] IDX_ENABLE = 8'h01;
  localparam logic [7:0] IDX_STOP = 8'h02;
  localparam logic [7:0] IDX_SPARE = 8'h03;
  localparam logic [7:0] IDX_MAKER = 8'h04;

  // ************************************************************
  // values after reset and writable-bit masks
  // ************************************************************
  localparam logic [7:0] MODE_RST = 8'h07;
  localparam logic [7:0] ENABLE_RST = 8'h66;
  localparam logic [7:0] STOP_RST = 8'h00;
  localparam logic [7:0] SPARE_RST = 8'h00;
  localparam logic [7:0] MODE_MASK = 8'hc7;
  localparam logic [7:0] PAIR_MASK = 8'h66;
  localparam logic [7:0] SPARE_MASK = 8'hff;

  // ************************************************************
  // field positions in the output mode register
  // ************************************************************
  localparam int MODE_NORMAL_BIT = 0;
  localparam int MODE_PLL_BIT = 1;
  localparam int MODE_BW_LOW_BIT = 2;
  localparam int MODE_STOP_TRI_BIT = 6;
  localparam int MODE_PD_TRI_BIT = 7;

  // ************************************************************
  // carrier types
  // ************************************************************
  // control pins as seen at the device boundary
  typedef struct packed {
    logic control_polarity_invert;
    logic oe_first;
    logic oe_last;
    logic clock_stop_n;
    logic power_down_n;
    logic pll_bandwidth_select_n;
    logic pll_mode_select;
  } cbs_pins_t;

  // register contents that steer the outputs
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] enable;
    logic [7:0] stop;
  } cbs_cfg_t;

  // per-pair output stage control, bit i is pair i
  typedef struct packed {
    logic [3:0] run;
    logic [3:0] true_high;
    logic [3:0] true_oe_n;
  } cbs_pair_ctrl_t;

  // pair fields sit at bits 1, 2, 5 and 6 of a register
  function automatic logic [3:0] pair_bits(input logic [7:0] v);
    pair_bits = {v[6], v[5], v[2], v[1]};
  endfunction

endpackage

/* File: logic/cbs_sync.sv */
// two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ns
module cbs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // first stage is read only by the second
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_q <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule

/* File: logic/cbs_out_ctrl.sv */
// combines control pins with register settings into per-pair output control
`timescale 1ns/1ns
module cbs_out_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // settings
  input cbs_pkg::cbs_cfg_t cfg,
  input cbs_pkg::cbs_pins_t pins,
  // output stage control
  output cbs_pkg::cbs_pair_ctrl_t pair_q,
  output logic normal_freq_q,
  output logic pll_mode_q,
  output logic bw_low_q
);

  logic oe_first;
  logic oe_last;
  logic stop_on;
  logic pd_on;
  logic [3:0] enabled;
  logic [3:0] stopped;

  // ************************************************************
  // pin sense and per-pair conditions
  // ************************************************************
  always_comb
  begin
    oe_first = pins.oe_first ^ pins.control_polarity_invert;
    oe_last = pins.oe_last ^ pins.control_polarity_invert;
    stop_on = ~(pins.clock_stop_n ^ pins.control_polarity_invert);
    pd_on = ~(pins.power_down_n ^ pins.control_polarity_invert);
    // only pairs 0 and 3 have a pin gate
    enabled = cbs_pkg::pair_bits(cfg.enable) & {oe_last, 1'b1, 1'b1, oe_first};
    stopped = cbs_pkg::pair_bits(cfg.stop) & {4{stop_on}};
  end

  // ************************************************************
  // output stage state
  // ************************************************************
  // power-down outranks disable, which outranks stop
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pair_q <= '0;
    end
    else if (pd_on)
    begin
      pair_q.run <= 4'h0;
      pair_q.true_high <= 4'hf;
      pair_q.true_oe_n <= {4{cfg.mode[cbs_pkg::MODE_PD_TRI_BIT]}};
    end
    else
    begin
      pair_q.run <= enabled & ~stopped;
      pair_q.true_high <= enabled & stopped;
      pair_q.true_oe_n <= enabled & stopped & {4{cfg.mode[cbs_pkg::MODE_STOP_TRI_BIT]}};
    end
  end

  // global mode selections; PLL mode and low bandwidth need both a pin and its register bit to allow, normal frequency follows its register bit alone
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      normal_freq_q <= 1'b1;
      pll_mode_q <= 1'b1;
      bw_low_q <= 1'b1;
    end
    else
    begin
      normal_freq_q <= cfg.mode[cbs_pkg::MODE_NORMAL_BIT];
      pll_mode_q <= cfg.mode[cbs_pkg::MODE_PLL_BIT] & pins.pll_mode_select;
      bw_low_q <= cfg.mode[cbs_pkg::MODE_BW_LOW_BIT] & pins.pll_bandwidth_select_n;
    end
  end

endmodule

/* File: dv/cbs_smbus_monitor.sv */
// port checker for the clock buffer management block
`timescale 1ns/1ns
module cbs_smbus_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // management bus
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // control pins
  input cbs_pkg::cbs_pins_t pins,
  // output stage control
  input cbs_pkg::cbs_pair_ctrl_t pair_ctrl,
  input wire logic normal_freq,
  input wire logic pll_mode,
  input wire logic bw_low
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // asserted levels after the polarity pin, as the device must read them
  wire logic inv = pins.control_polarity_invert;
  wire logic pd_on = (pins.power_down_n == inv);
  wire logic stop_on = (pins.clock_stop_n == inv);

  // ********
  // properties
  // ********
  // four cycles of a steady pin covers the three-cycle pin latency
  property p_pd_parks;
    pd_on [*4] |-> pair_ctrl.run == 4'h0 && pair_ctrl.true_high == 4'hf;
  endproperty
  a_pd_parks: assert property (p_pd_parks) else $error("pairs not parked");
  property p_pd_float;
    pd_on [*4] |-> pair_ctrl.true_oe_n == 4'h0 || pair_ctrl.true_oe_n == 4'hf;
  endproperty
  a_pd_float: assert property (p_pd_float) else $error("mixed float");
  property p_run_clean;
    (pair_ctrl.run & (pair_ctrl.true_high | pair_ctrl.true_oe_n)) == 4'h0;
  endproperty
  a_run_clean: assert property (p_run_clean) else $error("running pair parked");
  property p_no_park;
    (!pd_on && !stop_on) [*4] |-> pair_ctrl.true_high == 4'h0 && pair_ctrl.true_oe_n == 4'h0;
  endproperty
  a_no_park: assert property (p_no_park) else $error("parked without cause");
  property p_oe_first;
    (pins.oe_first == inv) [*4] |-> !pair_ctrl.run[0];
  endproperty
  a_oe_first: assert property (p_oe_first) else $error("pair 0 not gated");
  property p_oe_last;
    (pins.oe_last == inv) [*4] |-> !pair_ctrl.run[3];
  endproperty
  a_oe_last: assert property (p_oe_last) else $error("pair 3 not gated");
  property p_sda_pull;
    sda_out == 1'b0;
  endproperty
  a_sda_pull: assert property (p_sda_pull) else $error("data driven high");
  // the target may only move the data line while the bus clock is low
  property p_sda_low;
    $changed(sda_oe_n) |-> !scl;
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data moved in high");
  property p_pll_pin;
    !pins.pll_mode_select [*4] |-> !pll_mode;
  endproperty
  a_pll_pin: assert property (p_pll_pin) else $error("fan-out pin ignored");
  property p_bw_pin;
    !pins.pll_bandwidth_select_n [*4] |-> !bw_low;
  endproperty
  a_bw_pin: assert property (p_bw_pin) else $error("bandwidth pin ignored");
endmodule

bind cbs_smbus_top cbs_smbus_monitor u_mon (.clk(clk), .reset(reset), .scl(scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pins(pins),
  .pair_ctrl(pair_ctrl), .normal_freq(normal_freq), .pll_mode(pll_mode), .bw_low(bw_low));

/* File: dv/cbs_host_model.sv */
// management bus host model driving clock and data
`timescale 1ns/1ns
module cbs_host_model (
  // bus lines
  output logic scl,
  output logic sda_rel,
  // wired data level
  input wire logic sda
);
  // idle bus: clock stands still high, data released
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // one bit; low phase 200 ns, high phase 120 ns, data moved only in low
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    #100 scl = 1'b1;
    #60 r = sda;
    #60 scl = 1'b0;
    #100;
  endtask
  // start or repeated start; the odd delay keeps it off the system clock phase
  task automatic start_c;
    #13 sda_rel = 1'b1;
    #100 scl = 1'b1;
    #160 sda_rel = 1'b0;
    #160 scl = 1'b0;
    #100;
  endtask
  task automatic stop_c;
    sda_rel = 1'b0;
    #100 scl = 1'b1;
    #160 sda_rel = 1'b1;
    #160;
  endtask
  // byte out msb first, then the target's acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

/* File: dv/tb.sv */
// self-checking bench for the clock buffer management block
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module tb;
  // ********
  // signals
  // ********
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic scl, sda_rel, sda_out, sda_oe_n, normal_freq, pll_mode, bw_low;
  wire logic sda;
  cbs_pkg::cbs_pins_t pins;
  cbs_pkg::cbs_pair_ctrl_t pair_ctrl;
  logic [7:0] wd [5];
  logic [7:0] rd [6];
  logic [7:0] sh [3]; // expected mode, enable and stop registers
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  localparam logic [7:0] ID = 8'h5a; // arbitrary identity value

  cbs_smbus_top #(.MAKER_ID(ID)) dut (.clk(clk), .reset(reset), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pins(pins), .pair_ctrl(pair_ctrl),
    .normal_freq(normal_freq), .pll_mode(pll_mode), .bw_low(bw_low));
  cbs_host_model host (.scl(scl), .sda_rel(sda_rel), .sda(sda));
  assign sda = sda_rel & (sda_oe_n | sda_out); // pull-up wins when nobody pulls

  initial
  begin
    forever #20 clk = ~clk;
  end
  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      conclude();
    end
  end

  // ********
  // tasks
  // ********
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  // block write; bytes beyond the count field must be refused
  task automatic blk_wr(input logic [7:0] idx, input logic [7:0] cnt, input int n);
    logic a;
    host.start_c();
    host.put_byte({cbs_pkg::TARGET_ADDR, 1'b0}, a);
    `CHK(a, 1'b1)
    host.put_byte(idx, a);
    `CHK(a, 1'b1)
    host.put_byte(cnt, a);
    `CHK(a, 1'b1)
    for (int i = 0; i < n; i++)
    begin
      host.put_byte(wd[i], a);
      `CHK(a, (i < cnt))
    end
    host.stop_c();
  endtask
  // block read: count byte lands in rd[0], registers follow
  task automatic blk_rd(input logic [7:0] idx, input int n);
    logic a;
    host.start_c();
    host.put_byte({cbs_pkg::TARGET_ADDR, 1'b0}, a);
    host.put_byte(idx, a);
    host.put_byte(8'h01, a);
    host.start_c();
    host.put_byte({cbs_pkg::TARGET_ADDR, 1'b1}, a);
    `CHK(a, 1'b1)
    for (int i = 0; i <= n; i++) host.get_byte(i < n, rd[i]);
    `CHK(rd[0], cbs_pkg::READ_BYTE_COUNT)
    host.stop_c();
  endtask
  // drive pins, then compare outputs against the expected register state
  task automatic pin_chk(input cbs_pkg::cbs_pins_t p);
    cbs_pkg::cbs_pair_ctrl_t e;
    logic inv, pd, st;
    logic [3:0] en, sp;
    @(posedge clk);
    #2 pins = p;
    repeat (4) @(posedge clk);
    #2;
    inv = p.control_polarity_invert;
    pd = (p.power_down_n == inv);
    st = (p.clock_stop_n == inv);
    en = {sh[1][6] & (p.oe_last ^ inv), sh[1][5], sh[1][2], sh[1][1] & (p.oe_first ^ inv)};
    sp = {sh[2][6], sh[2][5], sh[2][2], sh[2][1]} & {4{st}};
    for (int i = 0; i < 4; i++)
    begin
      e.run[i] = !pd && en[i] && !sp[i];
      e.true_high[i] = pd || (en[i] && sp[i]);
      e.true_oe_n[i] = pd ? sh[0][7] : (en[i] && sp[i] && sh[0][6]);
    end
    `CHK(pair_ctrl, e)
    `CHK(pll_mode, sh[0][1] & p.pll_mode_select)
    `CHK(bw_low, sh[0][2] & p.pll_bandwidth_select_n)
    `CHK(normal_freq, sh[0][0])
  endtask

  // ********
  // tests
  // ********
  initial
  begin
    logic a;
    pins = 7'h3f;
    sh = '{8'h07, 8'h66, 8'h00};
    repeat (6) @(posedge clk);
    #2 reset = 1'b0;
    repeat (4) @(posedge clk);
    blk_rd(8'h00, 5);
    `CHK({rd[1], rd[2], rd[3], rd[4], rd[5]}, {8'h07, 8'h66, 8'h00, 8'h00, ID})
    pin_chk(7'h3f);
    done("reset values");
    host.start_c();
    host.put_byte(8'hde, a);
    `CHK(a, 1'b0)
    host.stop_c();
    done("foreign address");
    wd = '{8'hff, 8'hff, 8'hff, 8'h3c, 8'h00};
    blk_wr(8'h00, 8'h05, 5);
    sh = '{8'hc7, 8'h66, 8'h66};
    blk_rd(8'h00, 5);
    `CHK({rd[1], rd[2], rd[3], rd[4], rd[5]}, {8'hc7, 8'h66, 8'h66, 8'h3c, ID})
    pin_chk(7'h37);
    pin_chk(7'h3b);
    pin_chk(7'h4b);
    pin_chk(7'h0f);
    pin_chk(7'h3c);
    done("full write");
    wd[0] = 8'h02;
    wd[1] = 8'h24;
    blk_wr(8'h01, 8'h01, 2);
    sh[1] = 8'h02;
    blk_rd(8'h01, 2);
    `CHK({rd[1], rd[2]}, {8'h02, 8'h66})
    pin_chk(7'h3f);
    pin_chk(7'h37);
    done("count limit");
    wd[0] = 8'h00;
    blk_wr(8'h00, 8'h01, 1);
    sh[0] = 8'h00;
    pin_chk(7'h3f);
    pin_chk(7'h37);
    pin_chk(7'h3b);
    done("mode clear");
    wd[0] = 8'ha5;
    wd[1] = 8'h11;
    blk_wr(8'h03, 8'h02, 2);
    blk_rd(8'h03, 3);
    `CHK({rd[1], rd[2], rd[3]}, {8'ha5, ID, 8'h00})
    done("identity");
    conclude();
  end
endmodule
